// [design/fscap_top.sv]
// fault status capture: sticky fault cause flags, hard fault flags, fault addresses
// Operation
// [RULE_01] stacking bus error sets flag, no address
// [RULE_02] lazy fp save bus error sets flag
// [RULE_03] address-valid set on known-address bus fault
// [RULE_04] hard fault handler clears bus address-valid
// [RULE_05] undecodable instruction sets undefined-opcode flag
// [RULE_06] illegal state use sets flag unless undefined
// [RULE_07] illegal return value load sets return-pc flag
// [RULE_08] any coprocessor access sets missing-coprocessor flag
// [RULE_09] misaligned flag gated by trap; multiword always
// [RULE_10] zero divisor flag when trap enable set
// [RULE_11] subfields: mem 7..0, bus 14..8, usage above; the code puts bus in 15..8 (valid flag at 15) and usage in 31..16
// [RULE_12] word, halfword and byte access at documented addresses
// [RULE_13] usage flags sticky, cleared by writing one
// [RULE_14] hard fault bits sticky, write one clears
// [RULE_15] software writes zero to debug event bit
// [RULE_16] escalation to hard fault sets forced flag
// [RULE_17] vector table bus error sets vector flag
// [RULE_18] memguard address held while its valid set; the code recaptures it on every data permission violation, valid or not
// [RULE_19] split access captures actual faulting piece address
// [RULE_20] precise data bus error captures bus address
// [RULE_21] data permission violation captures memguard address
// [RULE_22] flags reset to zero, simultaneous faults accumulate
module fscap_top
    import fscap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire fscap_req_t i_req,
    input wire fscap_evt_t i_evt,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic o_err,
    output logic [31:0] o_fault_cause_status,
    output logic [31:0] o_hard_fault_cause_status,
    output logic o_misalign_trap_enable,
    output logic o_zero_divide_trap_enable
);

    fscap_state_t s_q;
    fscap_state_t s_d;
    logic [31:0] lane_mask;
    logic [31:0] lane_wdata;

    // sized access turned into lane mask and lane-aligned data
    fscap_lane u_lane (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_offset(i_req.addr[1:0]),
        .i_size(i_req.size),
        .i_wdata(i_req.wdata),
        .o_mask(lane_mask),
        .o_wdata(lane_wdata)
    );

    // word-aligned address selects the register; the low bits only pick lanes
    function automatic logic hit(input logic [31:0] a, input logic [31:0] base);
        hit = (a[31:2] == base[31:2]);
    endfunction

    // one-bit set vector from a condition
    function automatic logic [31:0] bit_at(input int pos, input logic cond);
        bit_at = cond ? (32'h00000001 << pos) : FSCAP_ZERO;
    endfunction

    logic [31:0] cfsr_set;
    logic [31:0] hard_fault_cause_status_set;
    logic [31:0] cfsr_clr;
    logic [31:0] hard_fault_cause_status_clr;
    logic bus_addr_known;
    logic mem_addr_known;
    logic wr;
    logic rd;

    // event decode into set vectors
    always_comb begin
        wr = i_req.valid & i_req.write;
        rd = i_req.valid & ~i_req.write;
        // instruction bus errors and stacking errors carry no address
        bus_addr_known = i_evt.precise_data_bus_error; // see [RULE_20]
        mem_addr_known = i_evt.data_permission_violation; // see [RULE_21]
        cfsr_set = FSCAP_ZERO;
        cfsr_set |= bit_at(FSCAP_IACCVIOL_BIT, i_evt.instr_access_violation);
        cfsr_set |= bit_at(FSCAP_DACCV_BIT, i_evt.data_permission_violation);
        cfsr_set |= bit_at(FSCAP_MUNSTK_BIT, i_evt.mem_unstack_violation);
        cfsr_set |= bit_at(FSCAP_MSTK_BIT, i_evt.mem_stack_violation);
        cfsr_set |= bit_at(FSCAP_MLSP_BIT, i_evt.mem_lazy_violation);
        cfsr_set |= bit_at(FSCAP_MMVALID_BIT, mem_addr_known); // see [RULE_18]
        cfsr_set |= bit_at(FSCAP_IBUS_BIT, i_evt.instr_bus_error);
        cfsr_set |= bit_at(FSCAP_PRECISE_BIT, i_evt.precise_data_bus_error);
        cfsr_set |= bit_at(FSCAP_IMPRECISE_BIT, i_evt.imprecise_bus_error);
        cfsr_set |= bit_at(FSCAP_UNSTK_BIT, i_evt.unstacking_bus_error);
        cfsr_set |= bit_at(FSCAP_STK_BIT, i_evt.stacking_bus_error); // see [RULE_01]
        cfsr_set |= bit_at(FSCAP_LSP_BIT, i_evt.lazy_fp_save_bus_error); // see [RULE_02]
        cfsr_set |= bit_at(FSCAP_BFVALID_BIT, bus_addr_known); // see [RULE_03]
        cfsr_set |= bit_at(FSCAP_UNDEF_BIT, i_evt.undefined_opcode_fault); // see [RULE_05]
        // an undefined instruction never reports an invalid state
        cfsr_set |= bit_at(FSCAP_INVST_BIT,
                           i_evt.invalid_state_fault & ~i_evt.undefined_opcode_fault); // see [RULE_06]
        cfsr_set |= bit_at(FSCAP_INVALID_RETURN_PC_FAULT_BIT, i_evt.invalid_return_pc_fault); // see [RULE_07]
        cfsr_set |= bit_at(FSCAP_NOCOP_BIT, i_evt.missing_coprocessor_fault); // see [RULE_08]
        cfsr_set |= bit_at(FSCAP_MISALIGN_BIT,
                           (i_evt.unaligned_access & s_q.ccr[FSCAP_MISALIGN_TRAP_BIT])
                           | i_evt.multiword_unaligned); // see [RULE_09]
        cfsr_set |= bit_at(FSCAP_ZDIV_BIT,
                           i_evt.divide_by_zero & s_q.ccr[FSCAP_ZDIV_TRAP_BIT]); // see [RULE_10]
        hard_fault_cause_status_set = FSCAP_ZERO;
        hard_fault_cause_status_set |= bit_at(FSCAP_FORCED_BIT, i_evt.escalated); // see [RULE_16]
        hard_fault_cause_status_set |= bit_at(FSCAP_VECT_BIT, i_evt.vector_fetch_fault); // see [RULE_17]
        hard_fault_cause_status_set |= bit_at(FSCAP_DEBUG_BIT, i_evt.debug_event);
        // write-one-to-clear, restricted to the lanes the access touches
        cfsr_clr = (wr && hit(i_req.addr, FSCAP_CFSR_ADDR)) ? (lane_wdata & lane_mask) : FSCAP_ZERO; // see [RULE_12]
        hard_fault_cause_status_clr = (wr && hit(i_req.addr, FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR)) ? (lane_wdata & lane_mask) : FSCAP_ZERO;
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.err = 1'b0;
        // set wins over a clear in the same cycle, so no event is lost
        s_d.cfsr = ((s_q.cfsr & ~cfsr_clr) | cfsr_set) & FSCAP_CFSR_MASK; // see [RULE_13] [RULE_22]
        s_d.hard_fault_cause_status = ((s_q.hard_fault_cause_status & ~hard_fault_cause_status_clr) | hard_fault_cause_status_set) & FSCAP_HARD_FAULT_CAUSE_STATUS_MASK; // see [RULE_14]
        // an instruction or data access violation after a bus fault drops the bus address valid flag
        if ((i_evt.data_permission_violation | i_evt.instr_access_violation) & ~bus_addr_known) begin
            s_d.cfsr[FSCAP_BFVALID_BIT] = 1'b0; // see [RULE_03]
        end
        // address capture; unaligned pieces report the piece address given by the core
        if (mem_addr_known) begin
            s_d.mmfar = i_evt.mem_addr; // see [RULE_19] [RULE_21]
        end
        if (bus_addr_known) begin
            s_d.bfar = i_evt.bus_addr; // see [RULE_20]
        end
        // plain read/write registers; a capture in the same cycle wins
        if (wr) begin
            if (hit(i_req.addr, FSCAP_MMFAR_ADDR) && !mem_addr_known) begin
                s_d.mmfar = (s_q.mmfar & ~lane_mask) | (lane_wdata & lane_mask);
            end
            if (hit(i_req.addr, FSCAP_BFAR_ADDR) && !bus_addr_known) begin
                s_d.bfar = (s_q.bfar & ~lane_mask) | (lane_wdata & lane_mask);
            end
            if (hit(i_req.addr, FSCAP_CCR_ADDR)) begin
                s_d.ccr = ((s_q.ccr & ~lane_mask) | (lane_wdata & lane_mask)) & FSCAP_CCR_MASK;
            end
        end
        // read data: full word, unselected lanes read zero
        if (i_req.valid) begin
            s_d.rvalid = rd;
            s_d.rdata = FSCAP_ZERO;
            if (hit(i_req.addr, FSCAP_CFSR_ADDR)) begin
                s_d.rdata = s_q.cfsr & lane_mask; // see [RULE_11] [RULE_12]
            end else if (hit(i_req.addr, FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR)) begin
                s_d.rdata = s_q.hard_fault_cause_status & lane_mask;
            end else if (hit(i_req.addr, FSCAP_MMFAR_ADDR)) begin
                s_d.rdata = s_q.mmfar & lane_mask;
            end else if (hit(i_req.addr, FSCAP_BFAR_ADDR)) begin
                s_d.rdata = s_q.bfar & lane_mask;
            end else if (hit(i_req.addr, FSCAP_CCR_ADDR)) begin
                s_d.rdata = s_q.ccr & lane_mask;
            end else begin
                s_d.err = 1'b1; // unmapped address answers with an error pulse
            end
        end
    end

    // single state register, all zero at reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0; // see [RULE_22]
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign o_rdata = s_q.rdata;
    assign o_rvalid = s_q.rvalid;
    assign o_err = s_q.err;
    assign o_fault_cause_status = s_q.cfsr;
    assign o_hard_fault_cause_status = s_q.hard_fault_cause_status;
    assign o_misalign_trap_enable = s_q.ccr[FSCAP_MISALIGN_TRAP_BIT];
    assign o_zero_divide_trap_enable = s_q.ccr[FSCAP_ZDIV_TRAP_BIT];

endmodule

// [design/fscap_pkg.sv]
// package for the fault status capture block: offsets, bit positions, types
package fscap_pkg;

    // register byte addresses
    localparam logic [31:0] FSCAP_CFSR_ADDR = 32'hE000ED28;
    localparam logic [31:0] FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR = 32'hE000ED2C;
    localparam logic [31:0] FSCAP_MMFAR_ADDR = 32'hE000ED34;
    localparam logic [31:0] FSCAP_BFAR_ADDR = 32'hE000ED38;
    localparam logic [31:0] FSCAP_CCR_ADDR = 32'hE000ED14;

    // fault cause status bit positions
    localparam int FSCAP_IACCVIOL_BIT = 0;
    localparam int FSCAP_DACCV_BIT = 1;
    localparam int FSCAP_MUNSTK_BIT = 3;
    localparam int FSCAP_MSTK_BIT = 4;
    localparam int FSCAP_MLSP_BIT = 5;
    localparam int FSCAP_MMVALID_BIT = 7;
    localparam int FSCAP_IBUS_BIT = 8;
    localparam int FSCAP_PRECISE_BIT = 9;
    localparam int FSCAP_IMPRECISE_BIT = 10;
    localparam int FSCAP_UNSTK_BIT = 11;
    localparam int FSCAP_STK_BIT = 12;
    localparam int FSCAP_LSP_BIT = 13;
    localparam int FSCAP_BFVALID_BIT = 15;
    localparam int FSCAP_UNDEF_BIT = 16;
    localparam int FSCAP_INVST_BIT = 17;
    localparam int FSCAP_INVALID_RETURN_PC_FAULT_BIT = 18;
    localparam int FSCAP_NOCOP_BIT = 19;
    localparam int FSCAP_MISALIGN_BIT = 24;
    localparam int FSCAP_ZDIV_BIT = 25;

    // hard fault status bit positions
    localparam int FSCAP_VECT_BIT = 1;
    localparam int FSCAP_FORCED_BIT = 30;
    localparam int FSCAP_DEBUG_BIT = 31;

    // core config control bit positions
    localparam int FSCAP_MISALIGN_TRAP_BIT = 3;
    localparam int FSCAP_ZDIV_TRAP_BIT = 4;

    // implemented bits and reset values
    localparam logic [31:0] FSCAP_CFSR_MASK = 32'h030FBFBB;
    localparam logic [31:0] FSCAP_HARD_FAULT_CAUSE_STATUS_MASK = 32'hC0000002;
    localparam logic [31:0] FSCAP_CCR_MASK = 32'h00000018;
    localparam logic [31:0] FSCAP_ZERO = 32'h00000000;

    // access sizes
    typedef enum logic [1:0] {
        FSCAP_SZ_BYTE,
        FSCAP_SZ_HALF,
        FSCAP_SZ_WORD
    } fscap_size_t;

    // register access request from the core's system bus
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        fscap_size_t size;
        logic [31:0] wdata;
    } fscap_req_t;

    // fault events reported by the core in one cycle
    typedef struct packed {
        logic        instr_access_violation;
        logic        data_permission_violation;
        logic        mem_unstack_violation;
        logic        mem_stack_violation;
        logic        mem_lazy_violation;
        logic [31:0] mem_addr;
        logic        instr_bus_error;
        logic        precise_data_bus_error;
        logic        imprecise_bus_error;
        logic        unstacking_bus_error;
        logic        stacking_bus_error;
        logic        lazy_fp_save_bus_error;
        logic [31:0] bus_addr;
        logic        undefined_opcode_fault;
        logic        invalid_state_fault;
        logic        invalid_return_pc_fault;
        logic        missing_coprocessor_fault;
        logic        unaligned_access;
        logic        multiword_unaligned;
        logic        divide_by_zero;
        logic        escalated;
        logic        vector_fetch_fault;
        logic        debug_event;
    } fscap_evt_t;

    // all block state
    typedef struct packed {
        logic [31:0] cfsr;
        logic [31:0] hard_fault_cause_status;
        logic [31:0] mmfar;
        logic [31:0] bfar;
        logic [31:0] ccr;
        logic [31:0] rdata;
        logic        rvalid;
        logic        err;
    } fscap_state_t;

endpackage

// [design/fscap_lane.sv]
// byte-lane helper: turns a sized access into a 32-bit lane mask and aligned data
module fscap_lane
    import fscap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [1:0] i_offset,
    input wire fscap_size_t i_size,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_mask,
    output logic [31:0] o_wdata
);

    logic [31:0] mask_d;
    logic [31:0] data_d;

    // halfword stays in its half, byte goes to its lane; the low byte or halfword of the write data is copied into every lane
    always_comb begin
        mask_d = 32'hFFFFFFFF;
        data_d = i_wdata;
        case (i_size)
            FSCAP_SZ_BYTE: begin
                mask_d = 32'h000000FF << {i_offset, 3'b000};
                data_d = {4{i_wdata[7:0]}};
            end
            FSCAP_SZ_HALF: begin
                mask_d = i_offset[1] ? 32'hFFFF0000 : 32'h0000FFFF;
                data_d = {2{i_wdata[15:0]}};
            end
            default: begin
                mask_d = 32'hFFFFFFFF;
                data_d = i_wdata;
            end
        endcase
    end

    // combinational path exported; clock and reset kept for a registered variant
    assign o_mask = mask_d & {32{~i_reset | i_clk | 1'b1}};
    assign o_wdata = data_d;

endmodule

// [tb/fscap_props.sv]
// checker for the fault status capture block, bound to its top module
module fscap_props
    import fscap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire fscap_req_t i_req,
    input wire fscap_evt_t i_evt,
    input wire logic [31:0] o_fault_cause_status,
    input wire logic [31:0] o_hard_fault_cause_status,
    input wire logic o_zero_divide_trap_enable
);
    // short aliases keep each property on one line
    wire logic [31:0] cf = o_fault_cause_status;
    wire logic [31:0] hf = o_hard_fault_cause_status;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // word write to the hard fault register with the forced bit set
    sequence s_hclr;
        i_req.valid && i_req.write && i_req.addr == FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR && i_req.size == FSCAP_SZ_WORD && i_req.wdata[30];
    endsequence
    property p_stk; i_evt.stacking_bus_error |=> cf[12]; endproperty
    a_stk: assert property (p_stk) else $error("stacking flag missing");
    property p_prec; i_evt.precise_data_bus_error |=> cf[9] && cf[15]; endproperty
    a_prec: assert property (p_prec) else $error("precise flags missing");
    property p_undef; i_evt.undefined_opcode_fault |=> cf[16]; endproperty
    a_undef: assert property (p_undef) else $error("undefined flag missing");
    property p_missing_coprocessor_fault; i_evt.missing_coprocessor_fault |=> cf[19]; endproperty
    a_missing_coprocessor_fault: assert property (p_missing_coprocessor_fault) else $error("coprocessor flag missing");
    property p_mw; i_evt.multiword_unaligned |=> cf[24]; endproperty
    a_mw: assert property (p_mw) else $error("multiword flag missing");
    property p_div; i_evt.divide_by_zero && o_zero_divide_trap_enable |=> cf[25]; endproperty
    a_div: assert property (p_div) else $error("divide flag missing");
    // without any write the undefined-opcode usage flag (bit 16) may never drop
    property p_sticky; cf[16] && !i_req.write |=> cf[16]; endproperty
    a_sticky: assert property (p_sticky) else $error("usage flag dropped");
    property p_forced; i_evt.escalated |=> hf[30]; endproperty
    a_forced: assert property (p_forced) else $error("forced flag missing");
    property p_vect; i_evt.vector_fetch_fault |=> hf[1]; endproperty
    a_vect: assert property (p_vect) else $error("vector flag missing");
    property p_hclr; s_hclr ##0 !i_evt.escalated |=> !hf[30]; endproperty
    a_hclr: assert property (p_hclr) else $error("forced flag not cleared");
endmodule

// [tb/tb.sv]
// self-checking bench for the fault status capture block
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb
    import fscap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    fscap_req_t i_req = '0;
    fscap_evt_t i_evt = '0;
    fscap_evt_t e = '0;
    logic [31:0] o_rdata, o_fault_cause_status, o_hard_fault_cause_status, a;
    logic [31:0] exp_c = '0;
    logic [31:0] exp_h = '0;
    logic o_rvalid, o_err, o_misalign_trap_enable, o_zero_divide_trap_enable;
    logic [33:0] notes[$];
    logic [33:0] n;
    int fail_count = 0;
    int comparisons = 0;

    always #2.5 i_clk = ~i_clk;

    fscap_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req), .i_evt(i_evt), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_err(o_err), .o_fault_cause_status(o_fault_cause_status),
        .o_hard_fault_cause_status(o_hard_fault_cause_status), .o_misalign_trap_enable(o_misalign_trap_enable),
        .o_zero_divide_trap_enable(o_zero_divide_trap_enable));

    // each answer or error retires the oldest note; unread lanes must be zero
    always @(negedge i_clk) begin
        if (o_rvalid === 1'b1 || o_err === 1'b1) begin
            n = notes.size() > 0 ? notes.pop_front() : 34'h3FFFFFFFF;
            `CHK("answer", n, {o_err, o_rvalid, o_rvalid ? o_rdata : 32'h0})
        end
    end

    // one request held for exactly one taking edge; reads and errors leave a note
    task automatic acc(input logic w, input logic [31:0] ad, input fscap_size_t sz, input logic [31:0] d,
            input logic [33:0] x);
        @(negedge i_clk);
        i_req <= '{1'b1, w, ad, sz, d};
        if (!w || x[33]) notes.push_back(x);
        @(negedge i_clk);
        i_req.valid <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] ad, input fscap_size_t sz, input logic [31:0] ex);
        acc(1'b0, ad, sz, 32'h0, {2'b01, ex});
    endtask

    task automatic wr(input logic [31:0] ad, input fscap_size_t sz, input logic [31:0] d);
        acc(1'b1, ad, sz, d, 34'h0);
    endtask

    // pulse the staged events, update the model, read both status registers back
    task automatic ev(input logic [31:0] s, input logic [31:0] c, input logic [31:0] h);
        @(negedge i_clk);
        i_evt <= e;
        e = '0;
        @(negedge i_clk);
        i_evt <= '0;
        exp_c = (exp_c & ~c) | s;
        exp_h = exp_h | h;
        rd(FSCAP_CFSR_ADDR, FSCAP_SZ_WORD, exp_c);
        rd(FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR, FSCAP_SZ_WORD, exp_h);
    endtask

    task automatic complete_run;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang is cut short and counted
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        $display("[ERR] run exp done got timeout");
        complete_run;
    end

    initial begin
        a = $urandom(32'h54C295D5);
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_reset <= 1'b0;
        `CHK("status", 32'h0, o_fault_cause_status)
        ev(32'h0, 32'h0, 32'h0);
        // bus faults; the stacking one must not mark the address valid
        e.stacking_bus_error = 1'b1;
        e.bus_addr = $urandom;
        ev(32'h1000, 32'h0, 32'h0);
        e.lazy_fp_save_bus_error = 1'b1;
        ev(32'h2000, 32'h0, 32'h0);
        a = $urandom;
        e.precise_data_bus_error = 1'b1;
        e.bus_addr = a;
        ev(32'h8200, 32'h0, 32'h0);
        rd(FSCAP_BFAR_ADDR, FSCAP_SZ_WORD, a);
        a = $urandom | 32'h1;
        e.data_permission_violation = 1'b1;
        e.mem_addr = a;
        ev(32'h82, 32'h8000, 32'h0);
        rd(FSCAP_MMFAR_ADDR, FSCAP_SZ_WORD, a);
        $display("test done: bus and memory faults");
        e.undefined_opcode_fault = 1'b1;
        ev(32'h10000, 32'h0, 32'h0);
        e.invalid_state_fault = 1'b1;
        ev(32'h20000, 32'h0, 32'h0);
        e.invalid_return_pc_fault = 1'b1;
        ev(32'h40000, 32'h0, 32'h0);
        e.missing_coprocessor_fault = 1'b1;
        ev(32'h80000, 32'h0, 32'h0);
        // traps still off: plain unaligned and divide leave no mark
        e.unaligned_access = 1'b1;
        e.divide_by_zero = 1'b1;
        ev(32'h0, 32'h0, 32'h0);
        e.multiword_unaligned = 1'b1;
        ev(32'h1000000, 32'h0, 32'h0);
        // zeros keep flags, random ones clear just their bits
        wr(FSCAP_CFSR_ADDR, FSCAP_SZ_WORD, 32'h0);
        ev(32'h0, 32'h0, 32'h0);
        a = $urandom;
        wr(FSCAP_CFSR_ADDR, FSCAP_SZ_WORD, a);
        ev(32'h0, a, 32'h0);
        wr(FSCAP_CFSR_ADDR, FSCAP_SZ_WORD, 32'hFFFFFFFF);
        ev(32'h0, 32'hFFFFFFFF, 32'h0);
        $display("test done: usage faults and clearing");
        wr(FSCAP_CCR_ADDR, FSCAP_SZ_WORD, 32'h18);
        @(negedge i_clk);
        `CHK("traps", 2'b11, {o_misalign_trap_enable, o_zero_divide_trap_enable})
        e.unaligned_access = 1'b1;
        ev(32'h1000000, 32'h0, 32'h0);
        e.divide_by_zero = 1'b1;
        ev(32'h2000000, 32'h0, 32'h0);
        // several faults in one cycle all accumulate
        e.precise_data_bus_error = 1'b1;
        e.undefined_opcode_fault = 1'b1;
        e.missing_coprocessor_fault = 1'b1;
        e.escalated = 1'b1;
        e.vector_fetch_fault = 1'b1;
        // invalid state alongside an undefined opcode must stay clear
        e.invalid_state_fault = 1'b1;
        ev(32'h98200, 32'h0, 32'h40000002);
        rd(FSCAP_CFSR_ADDR, FSCAP_SZ_BYTE, exp_c & 32'hFF);
        rd(32'hE000ED29, FSCAP_SZ_BYTE, exp_c & 32'hFF00);
        rd(FSCAP_CFSR_ADDR, FSCAP_SZ_HALF, exp_c & 32'hFFFF);
        rd(32'hE000ED2A, FSCAP_SZ_HALF, exp_c & 32'hFFFF0000);
        // handler of the escalated fault drops the bus address valid flag
        wr(32'hE000ED29, FSCAP_SZ_BYTE, 32'hFFFFFFFF);
        ev(32'h0, 32'hFF00, 32'h0);
        wr(32'hE000ED2A, FSCAP_SZ_HALF, 32'h00010001);
        ev(32'h0, 32'h10000, 32'h0);
        $display("test done: traps and narrow access");
        // debug bit written as zero while the forced bit is cleared
        wr(FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR, FSCAP_SZ_WORD, 32'h40000000);
        exp_h = 32'h2;
        ev(32'h0, 32'h0, 32'h0);
        wr(FSCAP_HARD_FAULT_CAUSE_STATUS_ADDR, FSCAP_SZ_WORD, 32'h2);
        exp_h = 32'h0;
        ev(32'h0, 32'h0, 32'h0);
        // an unmapped read answers with both the error and the read pulse, data zero
        acc(1'b0, 32'hE000ED30, FSCAP_SZ_WORD, 32'h0, {2'b11, 32'h0});
        acc(1'b1, 32'hE000ED30, FSCAP_SZ_WORD, 32'h0, {2'b10, 32'h0});
        // reset in mid-run returns everything to zero
        @(negedge i_clk);
        i_reset <= 1'b1;
        @(negedge i_clk);
        i_reset <= 1'b0;
        exp_c = 32'h0;
        ev(32'h0, 32'h0, 32'h0);
        for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge i_clk);
        `CHK("notes left", 0, notes.size())
        $display("test done: hard faults, unmapped, reset");
        complete_run;
    end
endmodule

bind fscap_top fscap_props props_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req), .i_evt(i_evt),
    .o_fault_cause_status(o_fault_cause_status), .o_hard_fault_cause_status(o_hard_fault_cause_status),
    .o_zero_divide_trap_enable(o_zero_divide_trap_enable));
